//--- hdl/port_s_pin_data.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
module port_s_pin_data
    import port_s_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output      logic                  s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output      logic                  s_axi_wready,
    output      logic [1:0]            s_axi_bresp,
    output      logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output      logic                  s_axi_arready,
    output      logic [31:0]           s_axi_rdata,
    output      logic [1:0]            s_axi_rresp,
    output      logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic [PORT_WIDTH-1:0] pin_in,
    output      logic [PORT_WIDTH-1:0] pin_out,
    output      logic [PORT_WIDTH-1:0] pin_oe_n,
    input  wire logic                  sync_serial_unit_zero_en,
    input  wire logic [3:0]            sync_serial_out,
    input  wire logic [3:0]            sync_serial_oe,
    output      logic [3:0]            sync_serial_in,
    input  wire logic                  async_serial_unit_one_en,
    input  wire logic [1:0]            async_one_out,
    input  wire logic [1:0]            async_one_oe,
    output      logic [1:0]            async_one_in,
    input  wire logic                  async_serial_unit_zero_en,
    input  wire logic [1:0]            async_zero_out,
    input  wire logic [1:0]            async_zero_oe,
    output      logic [1:0]            async_zero_in
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {WR_IDLE, WR_RESP} wr_phase_t;
    typedef enum logic [0:0] {RD_IDLE, RD_DATA} rd_phase_t;

    typedef struct packed {
        logic [PORT_WIDTH-1:0] port_s_pin_data;
        logic [PORT_WIDTH-1:0] port_s_direction;
        logic                  aw_held;
        logic [11:0]           aw_addr;
        logic                  w_held;
        logic [31:0]           w_data;
        logic [3:0]            w_strb;
        wr_phase_t             wr_phase;
        logic [1:0]            bresp;
        rd_phase_t             rd_phase;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;

    logic [PORT_WIDTH-1:0] periph_en;
    logic [PORT_WIDTH-1:0] periph_out;
    logic [PORT_WIDTH-1:0] periph_oe;
    logic [PORT_WIDTH-1:0] pin_level;
    logic [PORT_WIDTH-1:0] read_view;

    pin_sync_if pins ();

    // ------------------------------------------------------------------
    // Pin input buffering
    // ------------------------------------------------------------------
    assign pins.raw  = pin_in;
    assign pin_level = pins.level;

    pin_input_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pins)
    );

    // ------------------------------------------------------------------
    // Peripheral claim per bit, high bits first
    // ------------------------------------------------------------------
    assign periph_en  = {{4{sync_serial_unit_zero_en}},
                         {2{async_serial_unit_one_en}},
                         {2{async_serial_unit_zero_en}}};
    assign periph_out = {sync_serial_out, async_one_out, async_zero_out};
    assign periph_oe  = {sync_serial_oe, async_one_oe, async_zero_oe};

    // Peripherals see the buffered pin level at all times
    assign sync_serial_in = pin_level[SYNC_HI:SYNC_LO];
    assign async_one_in   = pin_level[ASYNC_ONE_HI:ASYNC_ONE_LO];
    assign async_zero_in  = pin_level[ASYNC_ZERO_HI:ASYNC_ZERO_LO];

    // Per-bit mux: peripheral wins, direction register is left alone
    generate
        for (genvar b = 0; b < PORT_WIDTH; b++) begin : g_pin
            always_comb begin
                if (periph_en[b]) begin
                    pin_out[b]  = periph_out[b];
                    pin_oe_n[b] = ~periph_oe[b];
                end else begin
                    pin_out[b]  = state.port_s_pin_data[b];
                    pin_oe_n[b] = ~state.port_s_direction[b];
                end
            end
            // Latch for outputs, pin for inputs
            assign read_view[b] = state.port_s_direction[b] ?
                                  state.port_s_pin_data[b] : pin_level[b];
            // An unclaimed pin set as input must never fight the outside driver
            a_gpio_input: assert property (@(posedge aclk) disable iff (!aresetn)
                !periph_en[b] && !state.port_s_direction[b] |-> pin_oe_n[b])
                else $error("input pin driven");
        end
    endgenerate

    // ------------------------------------------------------------------
    // AXI4-Lite slave; address and data may arrive in either order
    // ------------------------------------------------------------------
    assign s_axi_awready = !state.aw_held && state.wr_phase == WR_IDLE;
    assign s_axi_wready  = !state.w_held && state.wr_phase == WR_IDLE;
    assign s_axi_bvalid  = state.wr_phase == WR_RESP;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = state.rd_phase == RD_IDLE;
    assign s_axi_rvalid  = state.rd_phase == RD_DATA;
    assign s_axi_rdata   = state.rdata;
    assign s_axi_rresp   = state.rresp;

    always_comb begin
        next_state = state;
        // Capture write halves
        if (s_axi_awvalid && s_axi_awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_state.w_held = 1'b1;
            next_state.w_data = s_axi_wdata;
            next_state.w_strb = s_axi_wstrb;
        end
        // Commit once both halves are present
        case (state.wr_phase)
            WR_IDLE: begin
                if (state.aw_held && state.w_held) begin
                    next_state.aw_held  = 1'b0;
                    next_state.w_held   = 1'b0;
                    next_state.wr_phase = WR_RESP;
                    next_state.bresp    = RESP_OKAY;
                    case (state.aw_addr)
                        PIN_DATA_BYTE: begin
                            if (state.w_strb[0]) begin
                                next_state.port_s_pin_data = state.w_data[7:0];
                            end
                        end
                        DIRECTION_BYTE: begin
                            if (state.w_strb[0]) begin
                                next_state.port_s_direction = state.w_data[7:0];
                            end
                        end
                        default: begin
                            next_state.bresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    next_state.wr_phase = WR_IDLE;
                end
            end
            default: begin
                next_state.wr_phase = WR_IDLE;
            end
        endcase
        // Reads answer one cycle after the address is taken
        case (state.rd_phase)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    next_state.rd_phase = RD_DATA;
                    next_state.rresp    = RESP_OKAY;
                    case (s_axi_araddr)
                        PIN_DATA_BYTE:  next_state.rdata = {24'h000000, read_view};
                        DIRECTION_BYTE: next_state.rdata = {24'h000000,
                                                            state.port_s_direction};
                        default: begin
                            next_state.rdata = 32'h00000000;
                            next_state.rresp = RESP_SLVERR;
                        end
                    endcase
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    next_state.rd_phase = RD_IDLE;
                end
            end
            default: begin
                next_state.rd_phase = RD_IDLE;
            end
        endcase
    end

    // Register the whole state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state                  <= '0;
            state.port_s_pin_data  <= PIN_DATA_RESET;
            state.port_s_direction <= DIRECTION_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence data_write_s;
        state.wr_phase == WR_IDLE && state.aw_held && state.w_held
        && state.aw_addr == PIN_DATA_BYTE && state.w_strb[0];
    endsequence

    // Both write halves held: the commit cycle, whatever the address
    sequence write_commit_s;
        state.wr_phase == WR_IDLE && state.aw_held && state.w_held;
    endsequence

    // Read address taken on this edge
    sequence read_take_s;
        s_axi_arvalid && s_axi_arready;
    endsequence

    a_reset_clears: assert property (
        $rose(aresetn) |-> state.port_s_pin_data == PIN_DATA_RESET)
        else $error("pin data not zero after reset");
    a_dir_reset: assert property (
        $rose(aresetn) |-> state.port_s_direction == DIRECTION_RESET)
        else $error("direction not zero after reset");
    a_write_stores: assert property (
        data_write_s |=> state.port_s_pin_data == $past(state.w_data[7:0]))
        else $error("pin data write lost");
    a_write_answer: assert property (
        write_commit_s |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered");
    a_lane_off: assert property (
        write_commit_s ##0 !state.w_strb[0] |=> $stable(state.port_s_pin_data))
        else $error("write with lane off changed data");
    a_unmapped_write: assert property (
        write_commit_s ##0 (state.aw_addr != PIN_DATA_BYTE && state.aw_addr != DIRECTION_BYTE)
        |=> s_axi_bresp == RESP_SLVERR && $stable(state.port_s_pin_data)
            && $stable(state.port_s_direction))
        else $error("unmapped write not refused");
    a_read_answer: assert property (
        read_take_s |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_unmapped_read: assert property (
        read_take_s ##0 (s_axi_araddr != PIN_DATA_BYTE && s_axi_araddr != DIRECTION_BYTE)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
    a_read_dir: assert property (
        read_take_s ##0 s_axi_araddr == DIRECTION_BYTE
        |=> s_axi_rdata[7:0] == $past(state.port_s_direction) && s_axi_rresp == RESP_OKAY)
        else $error("direction read wrong");
    a_gpio_drive: assert property (
        !periph_en[0] && state.port_s_direction[0]
        |-> pin_out[0] == state.port_s_pin_data[0] && !pin_oe_n[0])
        else $error("gpio output not driven");
    a_read_latch: assert property (
        state.rd_phase == RD_IDLE && s_axi_arvalid && s_axi_araddr == PIN_DATA_BYTE
        |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(read_view))
        else $error("read view wrong");
    a_read_source: assert property (
        read_view == ((state.port_s_direction & state.port_s_pin_data)
                     | (~state.port_s_direction & pin_level)))
        else $error("read source mux wrong");
    a_sync_override: assert property (
        sync_serial_unit_zero_en |-> pin_out[SYNC_HI] == sync_serial_out[3]
        && pin_oe_n[SYNC_LO] == !sync_serial_oe[0])
        else $error("sync unit not overriding");
    a_async_one_own: assert property (
        async_serial_unit_one_en |-> pin_out[ASYNC_ONE_HI] == async_one_out[1])
        else $error("async one not overriding");
    a_async_zero_own: assert property (
        async_serial_unit_zero_en |-> pin_oe_n[ASYNC_ZERO_LO] == !async_zero_oe[0])
        else $error("async zero not overriding");
    a_dir_kept: assert property (
        state.wr_phase != WR_IDLE |=> $stable(state.port_s_direction))
        else $error("direction changed without write");
    // Peripheral enables may come and go; only a direction write moves the bits
    a_dir_only_write: assert property (
        !(state.wr_phase == WR_IDLE && state.aw_held && state.w_held
          && state.aw_addr == DIRECTION_BYTE && state.w_strb[0])
        |=> $stable(state.port_s_direction))
        else $error("direction changed without a write");

endmodule

//--- hdl/port_s_pkg.sv
package port_s_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] PIN_DATA_ADDR  = 12'h248;
    localparam logic [11:0] DIRECTION_ADDR = 12'h249;
    localparam logic [11:0] PIN_DATA_BYTE  = 12'h920;  // Four times the index
    localparam logic [11:0] DIRECTION_BYTE = 12'h924;
    localparam logic [7:0]  PIN_DATA_RESET  = 8'h00;
    localparam logic [7:0]  DIRECTION_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Pin group layout
    // ------------------------------------------------------------------
    localparam int PORT_WIDTH     = 8;
    localparam int SYNC_LO        = 4;
    localparam int SYNC_HI        = 7;
    localparam int ASYNC_ONE_LO   = 2;
    localparam int ASYNC_ONE_HI   = 3;
    localparam int ASYNC_ZERO_LO  = 0;
    localparam int ASYNC_ZERO_HI  = 1;

    // ------------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hdl/pin_sync_if.sv
// Raw pins into the synchroniser, filtered levels out
interface pin_sync_if;
    import port_s_pkg::*;
    logic [PORT_WIDTH-1:0] raw;
    logic [PORT_WIDTH-1:0] level;
    modport source (output raw, input level);
    modport sync   (input raw, output level);
endinterface

//--- hdl/pin_input_sync.sv
module pin_input_sync
    import port_s_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    pin_sync_if.sync  pins
);

    typedef struct packed {
        logic [PORT_WIDTH-1:0] first;
        logic [PORT_WIDTH-1:0] second;
        logic [PORT_WIDTH-1:0] third;
        logic [PORT_WIDTH-1:0] level;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // ------------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ------------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_state.first  = pins.raw;
        next_state.second = state.first;
        next_state.third  = state.second;
        for (int i = 0; i < PORT_WIDTH; i++) begin
            if (state.second[i] == state.third[i]) begin
                next_state.level[i] = state.third[i];
            end
        end
    end

    // Reset to constants only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pins.level = state.level;

endmodule

//--- verif/pin_partner.sv
// Far side of the port: outside drivers meet the port's own drivers on the wire
module pin_partner
    import port_s_pkg::*;
(
    input  wire logic [PORT_WIDTH-1:0] pin_out,
    input  wire logic [PORT_WIDTH-1:0] pin_oe_n,
    input  wire logic [PORT_WIDTH-1:0] ext_level,
    output      logic [PORT_WIDTH-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------------
    // The port wins where it drives; the outside source is weaker
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule

//--- verif/port_s_pin_data_tb_top.sv
module port_s_pin_data_tb_top;
    import port_s_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  pin_in, pin_out, pin_oe_n, ext_level = 8'h00;
    logic        sync_serial_unit_zero_en = 1'b0, async_serial_unit_one_en = 1'b0;
    logic        async_serial_unit_zero_en = 1'b0;
    logic [3:0]  sync_serial_out = 4'h0, sync_serial_oe = 4'h0, sync_serial_in;
    logic [1:0]  async_one_out = 2'h0, async_one_oe = 2'h0, async_one_in;
    logic [1:0]  async_zero_out = 2'h0, async_zero_oe = 2'h0, async_zero_in;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    logic [31:0] seed = 32'h0000003F;
    logic [7:0]  d, dir, ext, m, pout, poe, eoe, drv, lvl;
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;

    port_s_pin_data u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe_n,
        .sync_serial_unit_zero_en, .sync_serial_out, .sync_serial_oe, .sync_serial_in,
        .async_serial_unit_one_en, .async_one_out, .async_one_oe, .async_one_in,
        .async_serial_unit_zero_en, .async_zero_out, .async_zero_oe, .async_zero_in);
    pin_partner u_partner (.pin_out, .pin_oe_n, .ext_level, .pin_in);

    always #5 aclk = ~aclk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_write(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s,
                             input logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);  // Next request must not re-raise bready in this step
    endtask

    task automatic axi_read(input logic [11:0] a, input logic [33:0] e);
        exp_r.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);  // Next request must not re-raise rready in this step
    endtask

    // ------------------------------------------------------------------
    // Response monitor and hang guard
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        cycles++;
        if (aresetn && s_axi_rvalid && s_axi_rready) begin
            check("rdata", s_axi_rdata, exp_r[0][31:0]);
            check("rresp", {30'h0, s_axi_rresp}, {30'h0, exp_r[0][33:32]});
            void'(exp_r.pop_front());
        end
        if (aresetn && s_axi_bvalid && s_axi_bready) begin
            check("bresp", {30'h0, s_axi_bresp}, {30'h0, exp_b.pop_front()});
        end
        if (cycles == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        ext_level <= 8'hA5;
        repeat (8) @(posedge aclk);
        check("oe_n_reset", {24'h0, pin_oe_n}, 32'h000000FF);
        axi_read(DIRECTION_BYTE, {RESP_OKAY, 32'h0});
        axi_read(PIN_DATA_BYTE, {RESP_OKAY, 32'h000000A5});
        axi_write(DIRECTION_BYTE, 8'hFF, 4'hF, RESP_OKAY);
        axi_read(PIN_DATA_BYTE, {RESP_OKAY, 32'h0});
        // Unmapped place and a write with its byte lane off
        axi_read(12'h000, {RESP_SLVERR, 32'h0});
        axi_write(12'h000, 8'h5A, 4'hF, RESP_SLVERR);
        axi_write(PIN_DATA_BYTE, 8'h3C, 4'hF, RESP_OKAY);
        axi_write(PIN_DATA_BYTE, 8'hC3, 4'h0, RESP_OKAY);
        axi_read(PIN_DATA_BYTE, {RESP_OKAY, 32'h0000003C});
        // Random mixes; disabled peripherals toggle to show they are ignored
        for (int i = 0; i < 24; i++) begin
            seed = xorshift(seed);
            {d, dir, ext} = seed[23:0];
            axi_write(PIN_DATA_BYTE, d, 4'h1, RESP_OKAY);
            axi_write(DIRECTION_BYTE, dir, 4'hF, RESP_OKAY);
            ext_level <= ext;
            {sync_serial_out, async_one_out, async_zero_out} <= seed[31:24];
            {sync_serial_oe, async_one_oe, async_zero_oe} <= ~seed[31:24];
            repeat (8) @(posedge aclk);
            check("oe_n", {24'h0, pin_oe_n}, {24'h0, ~dir});
            check("pin_out", {24'h0, pin_out & dir}, {24'h0, d & dir});
            axi_read(PIN_DATA_BYTE, {RESP_OKAY, 24'h0, (dir & d) | (~dir & ext)});
        end
        // Each serial unit in turn claims its pins
        for (int u = 0; u < 3; u++) begin
            seed = xorshift(seed);
            m = (u == 0) ? 8'hF0 : ((u == 1) ? 8'h0C : 8'h03);
            {pout, poe, ext} = seed[23:0];
            {sync_serial_unit_zero_en, async_serial_unit_one_en, async_serial_unit_zero_en}
                <= 3'b100 >> u;
            {sync_serial_out, async_one_out, async_zero_out} <= pout;
            {sync_serial_oe, async_one_oe, async_zero_oe} <= poe;
            ext_level <= ext;
            repeat (8) @(posedge aclk);
            eoe = (m & ~poe) | (~m & ~dir);
            drv = ((m & pout) | (~m & d)) & ~eoe;
            lvl = drv | (eoe & ext);
            check("oe_n_claim", {24'h0, pin_oe_n}, {24'h0, eoe});
            check("out_claim", {24'h0, pin_out & ~eoe}, {24'h0, drv});
            check("unit_in", {24'h0, {sync_serial_in, async_one_in, async_zero_in} & m},
                  {24'h0, lvl & m});
            axi_read(DIRECTION_BYTE, {RESP_OKAY, 24'h0, dir});
        end
        finish_test();
    end
endmodule
